// ===== rtl/wdt_top.sv
// watchdog timer with window-locked mode register and supply reset
`timescale 1ns/100ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_top #(
  parameter int DELAY = `WDT_RST_DELAY
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire wdt_pkg::wdt_reg_wr_t REG_WR,
  input wire logic WDT_INSTR,
  input wire logic FIRST_INSTR,
  input wire logic HALT_MODE,
  input wire logic STOP_MODE,
  input wire logic XTAL_RUNNING,
  input wire logic RC_TICK,
  input wire logic XTAL_TICK,
  input wire logic PERMANENT,
  input wire logic SUPPLY_LOW,
  output logic GLOBAL_RESET,
  output logic RESET_DELAY,
  output logic CONFIG_RESET,
  output logic FLAGS_VALID,
  output wdt_pkg::wdt_flags_t FLAGS,
  output var wdt_pkg::wdt_mode_t MODE
);
  import wdt_pkg::*;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [1:0] lv_sync_reg;
  logic [1:0] rc_sync_reg;
  logic [1:0] xt_sync_reg;
  logic [1:0] xr_sync_reg;
  logic rc_prev_reg;
  logic xt_prev_reg;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      lv_sync_reg <= 2'b00;
      rc_sync_reg <= 2'b00;
      xt_sync_reg <= 2'b00;
      xr_sync_reg <= 2'b00;
      rc_prev_reg <= 1'b0;
      xt_prev_reg <= 1'b0;
    end else if (CE) begin
      lv_sync_reg <= {lv_sync_reg[0], SUPPLY_LOW};
      rc_sync_reg <= {rc_sync_reg[0], RC_TICK};
      xt_sync_reg <= {xt_sync_reg[0], XTAL_TICK};
      xr_sync_reg <= {xr_sync_reg[0], XTAL_RUNNING};
      rc_prev_reg <= rc_sync_reg[1];
      xt_prev_reg <= xt_sync_reg[1];
    end
  end
  logic rc_edge;
  logic xt_edge;
  assign rc_edge = rc_sync_reg[1] && !rc_prev_reg;
  assign xt_edge = xt_sync_reg[1] && !xt_prev_reg;

  function automatic logic [12:0] tap_limit(input logic [1:0] tap);
    unique case (tap)
      2'b00: tap_limit = 13'(`WDT_TAP0);
      2'b01: tap_limit = 13'(`WDT_TAP1);
      2'b10: tap_limit = 13'(`WDT_TAP2);
      2'b11: tap_limit = 13'(`WDT_TAP3);
    endcase
  endfunction : tap_limit

  wdt_mode_t mode_reg;
  wdt_mode_t mode_next;
  wdt_state_t state_reg;
  wdt_state_t state_next;
  logic [12:0] cnt_reg;
  logic [12:0] cnt_next;
  logic [7:0] dly_reg;
  logic [7:0] dly_next;
  logic stop_to_reg;
  logic stop_to_next;
  wdt_flags_t flags_reg;
  wdt_flags_t flags_next;
  logic fv_reg;
  logic fv_next;
  logic win_open;
  logic win_restart;
  logic mode_hit;
  logic tick;
  logic active;

  wdt_window #(
    .CYCLES(`WDT_WIN_CYCLES)
  ) u_window (
    .clk(CLK),
    .rst_n(rst_n),
    .ce(CE),
    .restart(win_restart),
    .first_instr(FIRST_INSTR),
    .open(win_open)
  );
  // window restarts during any watchdog reset delay, and in stop once the window has closed
  assign win_restart = (state_reg == ST_DELAY) || (STOP_MODE && !win_open);
  assign mode_hit = REG_WR.wr && REG_WR.bank == `WDT_MODE_BANK && REG_WR.addr == `WDT_MODE_ADDR;

  always_comb begin
    // source select; in stop, crystal only counts while it runs
    if (mode_reg.xtal_sel) begin
      tick = xt_edge && !(STOP_MODE && !xr_sync_reg[1]);
    end else begin
      tick = rc_edge;
    end
    active = PERMANENT
      || ((!HALT_MODE || mode_reg.halt_run) && (!STOP_MODE || mode_reg.stop_run));
  end

  always_comb begin
    mode_next = mode_reg;
    state_next = state_reg;
    cnt_next = cnt_reg;
    dly_next = dly_reg;
    stop_to_next = stop_to_reg;
    flags_next = flags_reg;
    fv_next = 1'b0;
    if (mode_hit && win_open && !win_restart) begin
      mode_next = REG_WR.data[4:0];
    end
    if (WDT_INSTR) begin
      flags_next = '{z: 1'b0, s: 1'b0, v: 1'b0};
      fv_next = 1'b1;
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (WDT_INSTR) begin
          state_next = ST_RUN;
          cnt_next = 13'h0000;
        end
      end
      ST_RUN: begin
        if (WDT_INSTR) begin
          cnt_next = 13'h0000;
        end else if (tick && active) begin
          if (cnt_reg + 13'h0001 >= tap_limit(mode_reg.tap)) begin
            state_next = ST_DELAY;
            dly_next = 8'h00;
            stop_to_next = STOP_MODE;
          end else begin
            cnt_next = cnt_reg + 13'h0001;
          end
        end
      end
      ST_DELAY: begin
        if (dly_reg + 8'h01 >= 8'(DELAY)) begin
          state_next = ST_IDLE;
          cnt_next = 13'h0000;
          // a normal timeout also restores mode defaults
          if (!stop_to_reg) begin
            mode_next = `WDT_MODE_RESET;
          end
        end else begin
          dly_next = dly_reg + 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `WDT_MODE_RESET;
      state_reg <= ST_IDLE;
      cnt_reg <= 13'h0000;
      dly_reg <= 8'h00;
      stop_to_reg <= 1'b0;
      flags_reg <= '0;
      fv_reg <= 1'b0;
    end else if (CE) begin
      mode_reg <= mode_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      dly_reg <= dly_next;
      stop_to_reg <= stop_to_next;
      flags_reg <= flags_next;
      fv_reg <= fv_next;
    end
  end

  assign RESET_DELAY = state_reg == ST_DELAY;
  assign CONFIG_RESET = RESET_DELAY && !stop_to_reg;
  assign GLOBAL_RESET = RESET_DELAY || lv_sync_reg[1] || !rst_n;
  assign FLAGS = flags_reg;
  assign FLAGS_VALID = fv_reg;
  assign MODE = mode_reg;

  AST_LOW_SUPPLY: assert property (@(posedge CLK) disable iff (!rst_n)
    (CE && SUPPLY_LOW) [*3] |-> GLOBAL_RESET) else $error("low supply without reset");
  AST_REFRESH: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
    (state_reg == ST_RUN && WDT_INSTR) |=> cnt_reg == 13'h0000) else $error("refresh did not reload");
  AST_START: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
    (state_reg == ST_IDLE && !WDT_INSTR) |=> state_reg != ST_RUN) else $error("started without instruction");
  AST_LOCK: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
    (!win_open && state_reg == ST_RUN) |=> $stable(mode_reg)) else $error("mode changed after window");
  AST_FLAGS: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
    WDT_INSTR |=> FLAGS_VALID) else $error("flags not updated");
  AST_HALT_HOLD: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
    (state_reg == ST_RUN && HALT_MODE && !mode_reg.halt_run && !PERMANENT && !WDT_INSTR)
    |=> $stable(cnt_reg)) else $error("counted in halt");
  AST_STOP_KEEP: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
    (state_reg == ST_DELAY && stop_to_reg) |=> $stable(mode_reg)) else $error("stop timeout cleared config");
  // last counted tick of the selected tap
  sequence s_terminal_tick;
    state_reg == ST_RUN && !WDT_INSTR && tick && active && (cnt_reg + 13'h0001 >= tap_limit(mode_reg.tap));
  endsequence
  AST_TIMEOUT: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
    s_terminal_tick |=> RESET_DELAY) else $error("terminal count without reset delay");
endmodule : wdt_top
`default_nettype wire

// ===== rtl/wdt_cfg.svh
// constants for the watchdog timer block
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_MODE_ADDR 8'h0f
`define WDT_MODE_BANK 4'hf
`define WDT_MODE_RESET 5'h0c
`define WDT_BIT_HALT 2
`define WDT_BIT_STOP 3
`define WDT_BIT_XTAL 4
`define WDT_WIN_CYCLES 60
`define WDT_TAP0 256
`define WDT_TAP1 512
`define WDT_TAP2 1024
`define WDT_TAP3 4096
`define WDT_RST_DELAY 16
`endif

// ===== rtl/wdt_pkg.sv
// types for the watchdog timer block
package wdt_pkg;
  typedef struct packed {
    logic xtal_sel;
    logic stop_run;
    logic halt_run;
    logic [1:0] tap;
  } wdt_mode_t;
  typedef struct packed {
    logic wr;
    logic [3:0] bank;
    logic [7:0] addr;
    logic [7:0] data;
  } wdt_reg_wr_t;
  typedef struct packed {
    logic z;
    logic s;
    logic v;
  } wdt_flags_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DELAY} wdt_state_t;
endpackage : wdt_pkg

// ===== rtl/wdt_window.sv
// write window counter for the watchdog mode register
`timescale 1ns/100ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_window #(
  parameter int CYCLES = `WDT_WIN_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic restart,
  input wire logic first_instr,
  output logic open
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic armed_reg;
  logic armed_next;
  always_comb begin
    cnt_next = cnt_reg;
    armed_next = armed_reg;
    if (restart) begin
      cnt_next = 8'h00;
      armed_next = 1'b0;
    end else if (!armed_reg) begin
      if (first_instr) begin
        armed_next = 1'b1;
      end
    end else if (cnt_reg < 8'(CYCLES)) begin
      cnt_next = cnt_reg + 8'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
      armed_reg <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      armed_reg <= armed_next;
    end
  end
  // open before the first instruction and for the counted cycles after it
  assign open = !armed_reg || cnt_reg < 8'(CYCLES);
endmodule : wdt_window
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the watchdog timer block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import wdt_pkg::*;
  localparam int DL = 4;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, wi = 1'b0, fi = 1'b0, halt = 1'b0, stop = 1'b0;
  logic xrun = 1'b1, rct = 1'b0, xtt = 1'b0, xen = 1'b1, perm = 1'b0, slow = 1'b0;
  wdt_reg_wr_t rw = '0;
  logic grst, rdly, cfg, fv, a, b, c;
  wdt_flags_t flags;
  wdt_mode_t mode;
  int errors = 0, checked = 0, n, w;
  always #10 clk = ~clk;
  // tick sources: rc always runs, crystal only while enabled
  always @(posedge clk) begin
    rct <= ~rct;
    if (xen) xtt <= ~xtt;
  end
  wdt_top #(.DELAY(DL)) dut (.CLK(clk), .RST_B(rst_b), .CE(ce), .REG_WR(rw), .WDT_INSTR(wi),
    .FIRST_INSTR(fi), .HALT_MODE(halt), .STOP_MODE(stop), .XTAL_RUNNING(xrun), .RC_TICK(rct),
    .XTAL_TICK(xtt), .PERMANENT(perm), .SUPPLY_LOW(slow), .GLOBAL_RESET(grst), .RESET_DELAY(rdly),
    .CONFIG_RESET(cfg), .FLAGS_VALID(fv), .FLAGS(flags), .MODE(mode));
  task results;
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task chk_bit(string nm, logic e, logic g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task chk_mode(string nm, wdt_mode_t e, wdt_mode_t g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_mode
  task chk_rng(string nm, int lo, int hi, int g);
    checked++;
    if (g < lo || g > hi) begin
      errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  task tk(int k);
    repeat (k) @(posedge clk);
  endtask : tk
  task wr(logic [3:0] bk, logic [7:0] ad, logic [7:0] d);
    rw <= '{1'b1, bk, ad, d};
    @(posedge clk);
    rw.wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task first;
    fi <= 1'b1;
    @(posedge clk);
    fi <= 1'b0;
    @(posedge clk);
  endtask : first
  task instr;
    wi <= 1'b1;
    @(posedge clk);
    wi <= 1'b0;
    @(posedge clk);
    chk_bit("flags_valid", 1'b1, fv);
    chk_bit("flags", 1'b0, |flags);
  endtask : instr
  // watch for any reset delay and whether global reset stays high throughout
  task watch(int k, output logic anyd, output logic allg);
    anyd = 1'b0;
    allg = 1'b1;
    repeat (k) begin
      @(posedge clk);
      if (rdly !== 1'b0) anyd = 1'b1;
      if (grst !== 1'b1) allg = 1'b0;
    end
  endtask : watch
  // cycles until the reset delay starts, its length with global reset high, config reset seen
  task measure(output int cnt, output int wid, output logic cf);
    cnt = 0;
    wid = 0;
    cf = 1'b0;
    while (rdly !== 1'b1 && cnt < 6000) begin
      @(posedge clk);
      cnt++;
    end
    while (rdly === 1'b1 && wid < 100) begin
      if (grst === 1'b1) wid++;
      if (cfg === 1'b1) cf = 1'b1;
      @(posedge clk);
    end
  endtask : measure
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
  initial begin
    tk(8);
    chk_bit("grst_in_reset", 1'b1, grst);
    rst_b <= 1'b1;
    tk(5);
    chk_mode("mode_default", 5'h0c, mode);
    watch(1500, a, b);
    chk_bit("no_start", 1'b0, a);
    first();
    tk(45);
    wr(4'hf, 8'h0f, 8'he0);
    wr(4'he, 8'h0f, 8'h02);
    wr(4'hf, 8'h0e, 8'h02);
    chk_mode("mode_write", 5'h00, mode);
    tk(7);
    wr(4'hf, 8'h0f, 8'h01);
    chk_mode("window_last", 5'h01, mode);
    wr(4'hf, 8'h0f, 8'h0e);
    chk_mode("mode_locked", 5'h01, mode);
    instr();
    ce <= 1'b0;
    watch(1100, a, b);
    chk_bit("ce_freeze", 1'b0, a);
    ce <= 1'b1;
    halt <= 1'b1;
    watch(1500, a, b);
    chk_bit("halt_quiet", 1'b0, a);
    halt <= 1'b0;
    tk(800);
    instr();
    measure(n, w, c);
    chk_rng("tap01_refresh", 1016, 1040, n);
    chk_rng("delay_len", DL, DL, w);
    chk_bit("cfg_reset", 1'b1, c);
    tk(2);
    chk_mode("mode_after_wdt", 5'h0c, mode);
    first();
    tk(4);
    wr(4'hf, 8'h0f, 8'h18);
    instr();
    halt <= 1'b1;
    perm <= 1'b1;
    measure(n, w, c);
    chk_rng("permanent_xtal", 504, 528, n);
    perm <= 1'b0;
    halt <= 1'b0;
    tk(2);
    first();
    tk(4);
    wr(4'hf, 8'h0f, 8'h18);
    instr();
    stop <= 1'b1;
    xrun <= 1'b0;
    watch(600, a, b);
    chk_bit("xtal_gated", 1'b0, a);
    xen <= 1'b0;
    watch(600, a, b);
    chk_bit("xtal_halted", 1'b0, a);
    xen <= 1'b1;
    xrun <= 1'b1;
    measure(n, w, c);
    chk_rng("stop_xtal", 504, 528, n);
    chk_bit("stop_keeps_cfg", 1'b0, c);
    tk(2);
    chk_mode("stop_mode_kept", 5'h18, mode);
    stop <= 1'b0;
    slow <= 1'b1;
    tk(4);
    watch(50, a, b);
    chk_bit("supply_reset", 1'b1, b);
    slow <= 1'b0;
    tk(20);
    chk_bit("supply_release", 1'b0, grst);
    results();
  end
endmodule : tb
`default_nettype wire
